// >>> rtl/tps_pkg.sv
// Package for the two-port 512x9 / 256x18 SRAM block: register map, field
// positions, reset values, width codes and the bundles carried between
// the pin sampler and the core.
// Assumes a single core clock with every pin sampled into its domain.
package tps_pkg;

  // Width select codes
  localparam logic [1:0] WIDTH_X9 = 2'h1;
  localparam logic [1:0] WIDTH_X18 = 2'h2;

  // Array geometry
  localparam int ARRAY_WORDS = 512;
  localparam int SCAN_BITS = 4608;
  localparam logic [3:0] SCAN_LAST_BIT = 4'h8;
  localparam logic [8:0] SCAN_LAST_WORD = 9'h1FF;

  // Register indices on the plain register port
  localparam logic [1:0] REG_CONFIG = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_READ_WORD = 2'h2;

  // Configuration field positions
  localparam int CFG_WW_LSB = 0;
  localparam int CFG_RW_LSB = 2;
  localparam int CFG_PIPE_BIT = 4;
  localparam int CFG_WFALL_BIT = 5;
  localparam int CFG_RFALL_BIT = 6;

  // Status field positions
  localparam int STS_WW_BAD_BIT = 0;
  localparam int STS_RW_BAD_BIT = 1;
  localparam int STS_SCAN_DONE_BIT = 2;

  // Reset values
  localparam logic [1:0] CFG_WW_RESET = 2'h1;
  localparam logic [1:0] CFG_RW_RESET = 2'h1;
  localparam logic CFG_PIPE_RESET = 1'b0;
  localparam logic CFG_FALL_RESET = 1'b0;

  // Sampled pins of both ports and the preload scan
  typedef struct packed {
    logic writeClk;
    logic writeStrobe;
    logic [8:0] write_location;
    logic [17:0] write_data_in;
    logic readClk;
    logic readStrobe;
    logic [8:0] read_location;
    logic scanClk;
    logic scanBit;
  } tps_pins_t;

  localparam int PINS_W = $bits(tps_pins_t);

  typedef struct packed {
    logic readFall;
    logic writeFall;
    logic pipeOn;
    logic [1:0] read_width_sel;
    logic [1:0] write_width_sel;
  } tps_cfg_t;

endpackage

// >>> rtl/tps_sync3.sv
// Three-stage pin sampler with agreement filter.
// Assumes inputs are asynchronous to clk; output changes only when
// the second and third stages agree.
`timescale 1ns/10ps
module tps_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1Reg;
  logic [W-1:0] s2Reg;
  logic [W-1:0] s3Reg;
  logic [W-1:0] qReg;
  logic [W-1:0] qNext;

  always_comb begin
    for (int i = 0; i < W; i++) begin
      qNext[i] = (s2Reg[i] == s3Reg[i]) ? s3Reg[i] : qReg[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1Reg <= '0;
      s2Reg <= '0;
      s3Reg <= '0;
      qReg <= '0;
    end else begin
      s1Reg <= d;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
      qReg <= qNext;
    end
  end

  assign q = qReg;

endmodule

// >>> rtl/tps_two_port_sram.sv
// Two-port 512x9 / 256x18 synchronous SRAM with serial preload.
// Assumes port clocks, strobes, data and scan arrive as pins and are
// sampled into core_clk; configuration sits behind a plain register port.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
module tps_two_port_sram #(
  parameter bit WRITE_ACT_HIGH = 1'b0,
  parameter bit READ_ACT_HIGH = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Write port pins
  input wire logic writeClk,
  input wire logic writeStrobe,
  input wire logic [8:0] write_location,
  input wire logic [17:0] write_data_in,
  // Read port pins
  input wire logic readClk,
  input wire logic readStrobe,
  input wire logic [8:0] read_location,
  output logic [17:0] readData,
  // Serial preload pins
  input wire logic scanClk,
  input wire logic scanBit,
  // Register port
  input wire logic [1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData
);

  tps_pkg::tps_pins_t pinsRaw;
  tps_pkg::tps_pins_t pins;

  assign pinsRaw.writeClk = writeClk;
  assign pinsRaw.writeStrobe = writeStrobe;
  assign pinsRaw.write_location = write_location;
  assign pinsRaw.write_data_in = write_data_in;
  assign pinsRaw.readClk = readClk;
  assign pinsRaw.readStrobe = readStrobe;
  assign pinsRaw.read_location = read_location;
  assign pinsRaw.scanClk = scanClk;
  assign pinsRaw.scanBit = scanBit;

  tps_sync3 #(
    .W(tps_pkg::PINS_W)
  ) pinSync (
    .clk(core_clk),
    .rst_n(rst_n),
    .d(pinsRaw),
    .q(pins)
  );

  // Storage, never reset
  logic [8:0] mem [0:tps_pkg::ARRAY_WORDS-1];

  // Configuration and edge state
  tps_pkg::tps_cfg_t cfg_reg;
  tps_pkg::tps_cfg_t cfg_next;
  logic wClkPrev_reg;
  logic rClkPrev_reg;
  logic sClkPrev_reg;
  logic wClkPrev_next;
  logic rClkPrev_next;
  logic sClkPrev_next;

  // Read path state
  logic [17:0] readData_reg;
  logic [17:0] readData_next;
  logic [17:0] pipeWord_reg;
  logic [17:0] pipeWord_next;

  // Preload state
  logic [8:0] scanShift_reg;
  logic [8:0] scanShift_next;
  logic [3:0] scanBitCnt_reg;
  logic [3:0] scanBitCnt_next;
  logic [8:0] scanWord_reg;
  logic [8:0] scanWord_next;
  logic scanDone_reg;
  logic scanDone_next;

  // Register port answer
  logic [31:0] regRdData_reg;
  logic [31:0] regRdData_next;

  // Decoded events
  logic wEdge;
  logic rEdge;
  logic sEdge;
  logic wAct;
  logic rAct;
  logic wwOk;
  logic rwOk;
  logic [17:0] fetch;
  logic memWrLo;
  logic memWrHi;
  logic [8:0] memAddrLo;
  logic [8:0] memAddrHi;
  logic [8:0] memDataLo;
  logic [8:0] memDataHi;

  always_comb begin
    // Edge choice per port
    wEdge = cfg_reg.writeFall ? (wClkPrev_reg & ~pins.writeClk)
                              : (~wClkPrev_reg & pins.writeClk);
    rEdge = cfg_reg.readFall ? (rClkPrev_reg & ~pins.readClk)
                             : (~rClkPrev_reg & pins.readClk);
    sEdge = ~sClkPrev_reg & pins.scanClk;
    wAct = pins.writeStrobe == WRITE_ACT_HIGH;
    rAct = pins.readStrobe == READ_ACT_HIGH;
    wwOk = (cfg_reg.write_width_sel == tps_pkg::WIDTH_X9) ||
           (cfg_reg.write_width_sel == tps_pkg::WIDTH_X18);
    rwOk = (cfg_reg.read_width_sel == tps_pkg::WIDTH_X9) ||
           (cfg_reg.read_width_sel == tps_pkg::WIDTH_X18);
  end

  // Fetch, little-endian pairing of 9-bit words
  always_comb begin
    if (cfg_reg.read_width_sel == tps_pkg::WIDTH_X18) begin
      fetch = {mem[{pins.read_location[7:0], 1'b1}],
               mem[{pins.read_location[7:0], 1'b0}]};
    end else begin
      fetch = {9'h000, mem[pins.read_location]};
    end
  end

  // Write path; preload wins when both land together
  always_comb begin
    memWrLo = 1'b0;
    memWrHi = 1'b0;
    memAddrLo = pins.write_location;
    memAddrHi = pins.write_location;
    memDataLo = pins.write_data_in[8:0];
    memDataHi = pins.write_data_in[17:9];
    if (sEdge && (scanBitCnt_reg == tps_pkg::SCAN_LAST_BIT)) begin
      memWrLo = 1'b1;
      memAddrLo = scanWord_reg;
      memDataLo = {pins.scanBit, scanShift_reg[8:1]};
    end else if (wEdge && wAct && wwOk) begin
      memWrLo = 1'b1;
      if (cfg_reg.write_width_sel == tps_pkg::WIDTH_X18) begin
        memWrHi = 1'b1;
        memAddrLo = {pins.write_location[7:0], 1'b0};
        memAddrHi = {pins.write_location[7:0], 1'b1};
      end
    end
  end

  // Array writes run only with reset released
  always_ff @(posedge core_clk) begin
    if (rst_n && memWrLo) begin
      mem[memAddrLo] <= memDataLo;
    end
    if (rst_n && memWrHi) begin
      mem[memAddrHi] <= memDataHi;
    end
  end

  // Read path next state
  always_comb begin
    readData_next = readData_reg;
    pipeWord_next = pipeWord_reg;
    if (rEdge && rAct && rwOk) begin
      if (cfg_reg.pipeOn) begin
        pipeWord_next = fetch;
        readData_next = pipeWord_reg;
      end else begin
        readData_next = fetch;
      end
    end
  end

  // Preload next state, LSB first
  always_comb begin
    scanShift_next = scanShift_reg;
    scanBitCnt_next = scanBitCnt_reg;
    scanWord_next = scanWord_reg;
    scanDone_next = scanDone_reg;
    if (sEdge) begin
      scanShift_next = {pins.scanBit, scanShift_reg[8:1]};
      if (scanBitCnt_reg == tps_pkg::SCAN_LAST_BIT) begin
        scanBitCnt_next = 4'h0;
        scanWord_next = scanWord_reg + 9'h001;
        if (scanWord_reg == tps_pkg::SCAN_LAST_WORD) begin
          scanDone_next = 1'b1;
        end
      end else begin
        scanBitCnt_next = scanBitCnt_reg + 4'h1;
      end
    end
  end

  // Register port next state
  always_comb begin
    cfg_next = cfg_reg;
    regRdData_next = 32'h0000_0000;
    if (regWr && (regAddr == tps_pkg::REG_CONFIG)) begin
      cfg_next = regWrData[$bits(tps_pkg::tps_cfg_t)-1:0];
    end
    if (regRd) begin
      case (regAddr)
        tps_pkg::REG_CONFIG: begin
          regRdData_next[$bits(tps_pkg::tps_cfg_t)-1:0] = cfg_reg;
        end
        tps_pkg::REG_STATUS: begin
          regRdData_next[tps_pkg::STS_WW_BAD_BIT] = ~wwOk;
          regRdData_next[tps_pkg::STS_RW_BAD_BIT] = ~rwOk;
          regRdData_next[tps_pkg::STS_SCAN_DONE_BIT] = scanDone_reg;
        end
        tps_pkg::REG_READ_WORD: begin
          regRdData_next[17:0] = readData_reg;
        end
        default: begin
          regRdData_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // Port clock history next state
  always_comb begin
    wClkPrev_next = pins.writeClk;
    rClkPrev_next = pins.readClk;
    sClkPrev_next = pins.scanClk;
  end

  // Configuration and register answer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg.write_width_sel <= tps_pkg::CFG_WW_RESET;
      cfg_reg.read_width_sel <= tps_pkg::CFG_RW_RESET;
      cfg_reg.pipeOn <= tps_pkg::CFG_PIPE_RESET;
      cfg_reg.writeFall <= tps_pkg::CFG_FALL_RESET;
      cfg_reg.readFall <= tps_pkg::CFG_FALL_RESET;
      regRdData_reg <= 32'h0000_0000;
    end else begin
      cfg_reg <= cfg_next;
      regRdData_reg <= regRdData_next;
    end
  end

  // Port clock history
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wClkPrev_reg <= 1'b0;
      rClkPrev_reg <= 1'b0;
      sClkPrev_reg <= 1'b0;
    end else begin
      wClkPrev_reg <= wClkPrev_next;
      rClkPrev_reg <= rClkPrev_next;
      sClkPrev_reg <= sClkPrev_next;
    end
  end

  // Read path hold registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      readData_reg <= 18'h0_0000;
      pipeWord_reg <= 18'h0_0000;
    end else begin
      readData_reg <= readData_next;
      pipeWord_reg <= pipeWord_next;
    end
  end

  // Preload shifter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scanShift_reg <= 9'h000;
      scanBitCnt_reg <= 4'h0;
      scanWord_reg <= 9'h000;
      scanDone_reg <= 1'b0;
    end else begin
      scanShift_reg <= scanShift_next;
      scanBitCnt_reg <= scanBitCnt_next;
      scanWord_reg <= scanWord_next;
      scanDone_reg <= scanDone_next;
    end
  end

  assign readData = readData_reg;
  assign regRdData = regRdData_reg;

endmodule

// >>> bench/tps_two_port_sram_props.sv
// Checker for the two-port SRAM: read data timing and register echoes.
// Assumes the default build with both strobes active low.
`timescale 1ns/10ps
module tps_two_port_sram_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Read port
  input wire logic readClk,
  input wire logic readStrobe,
  input wire logic [17:0] readData,
  // Register port
  input wire logic [1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [6:0] cfgTrack;
  logic clkQ;
  logic [3:0] sinceClk;
  // Config mirror and age of the last read clock change
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgTrack <= 7'h05;
      clkQ <= 1'b0;
      sinceClk <= 4'hF;
    end else begin
      if (regWr && regAddr == 2'h0) begin
        cfgTrack <= regWrData[6:0];
      end
      clkQ <= readClk;
      if (readClk != clkQ) begin
        sinceClk <= 4'h0;
      end else if (sinceClk != 4'hF) begin
        sinceClk <= sinceClk + 4'h1;
      end
    end
  end
  chk_reset_clears: assert property (@(posedge core_clk) disable iff (1'b0)
    !rst_n |-> readData == 18'h0 && regRdData == 32'h0) else $error("reset");
  chk_hold_idle: assert property ($changed(readData)
    |-> !$past(readStrobe, 6)) else $error("change without strobe");
  chk_edge_paced: assert property ($changed(readData)
    |-> sinceClk inside {[2:8]}) else $error("change off read edge");
  chk_x9_upper: assert property ($changed(readData) && cfgTrack[3:2] == 2'h1
    |-> readData[17:9] == 9'h0) else $error("upper bits set");
  chk_reg_pulse: assert property (regRdData != 32'h0
    |-> $past(regRd)) else $error("read data not a pulse");
  chk_word_echo: assert property ($past(regRd) && $past(regAddr) == 2'h2
    |-> regRdData == {14'h0, $past(readData)}) else $error("word echo");
  chk_cfg_echo: assert property ($past(regRd) && $past(regAddr) == 2'h0
    |-> regRdData[6:0] == cfgTrack) else $error("config echo");
  chk_width_flag: assert property ($past(regRd) && $past(regAddr) == 2'h1
    |-> regRdData[1:0] == {~^cfgTrack[3:2], ~^cfgTrack[1:0]})
    else $error("width flags");
  cover property ($rose(readClk));
  cover property (regRdData[2]);
  cover property ($changed(readData) && cfgTrack[4]);
endmodule

// >>> bench/tps_user_model.sv
// User fabric model driving the write, read and preload pins.
// Assumes strobes active low and pins paced by core_clk.
`timescale 1ns/10ps
module tps_user_model (
  // Pacing clock
  input wire logic core_clk,
  // Write port
  output logic writeClk,
  output logic writeStrobe,
  output logic [8:0] write_location,
  output logic [17:0] write_data_in,
  // Read port
  output logic readClk,
  output logic readStrobe,
  output logic [8:0] read_location,
  input wire logic [17:0] readData,
  output logic [17:0] midData,
  // Preload
  output logic scanClk,
  output logic scanBit
);
  initial begin
    {writeClk, readClk, scanClk, scanBit} = 4'h0;
    {writeStrobe, readStrobe} = 2'h3;
    {write_location, write_data_in, read_location, midData} = '0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Idle lines show the inverse, never the last value
  task automatic wr(input logic [8:0] l, input logic [17:0] d, input logic en);
    write_location <= l;
    write_data_in <= d;
    writeStrobe <= ~en;
    cyc(5);
    writeClk <= 1'b1;
    cyc(7);
    writeClk <= 1'b0;
    cyc(7);
    writeStrobe <= 1'b1;
    write_location <= ~l;
    write_data_in <= ~d;
    cyc(1);
  endtask
  task automatic rd(input logic [8:0] l, input logic en);
    read_location <= l;
    readStrobe <= ~en;
    cyc(5);
    readClk <= 1'b1;
    cyc(7);
    midData <= readData;
    readClk <= 1'b0;
    cyc(7);
    readStrobe <= 1'b1;
    read_location <= ~l;
    cyc(1);
  endtask
  // Word w holds w, LSB first, word 0 first
  task automatic preload();
    for (int i = 0; i < 4608; i++) begin
      scanBit <= 1'((i / 9) >> (i % 9));
      cyc(5);
      scanClk <= 1'b1;
      cyc(5);
      scanClk <= 1'b0;
    end
  endtask
endmodule

// >>> bench/tps_two_port_sram_tb_top.sv
// Testbench for the two-port SRAM: table of width cases, then refusal,
// strobe, pipe, edge, concurrency and reset cases.
// Assumes tps_user_model on the pins and the checker bound below.
`timescale 1ns/10ps
module tps_two_port_sram_tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] regAddr = 2'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic writeClk, writeStrobe, readClk, readStrobe, scanClk, scanBit;
  logic [8:0] write_location, read_location;
  logic [17:0] write_data_in, readData, midData;
  int error_cnt = 0;
  int checks_done = 0;
  int tick = 0;
  // Config, write location, data, read location, expected word
  localparam logic [60:0] ROWS [4] = '{
    {7'h05, 9'h003, 18'h0_01A5, 9'h003, 18'h0_01A5},
    {7'h0A, 9'h002, 18'h2_B3C4, 9'h002, 18'h2_B3C4},
    {7'h06, 9'h004, 18'h1_2345, 9'h009, 18'h0_0091},
    {7'h09, 9'h014, 18'h0_00AB, 9'h00A, 18'h0_2AAB}};
  initial forever #2.5 core_clk = ~core_clk;
  tps_two_port_sram uut (.core_clk, .rst_n, .writeClk, .writeStrobe,
    .write_location, .write_data_in, .readClk, .readStrobe, .read_location,
    .readData, .scanClk, .scanBit, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData);
  tps_user_model pm (.core_clk, .writeClk, .writeStrobe, .write_location,
    .write_data_in, .readClk, .readStrobe, .read_location, .readData,
    .midData, .scanClk, .scanBit);
  task test_done();
    $display("Errors %0d of %0d checks", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    tick++;
    if (tick == 60000) begin
      error_cnt++;
      test_done();
    end
  end
  task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task cd(input logic [17:0] e);
    cmp("readData", {14'h0, e}, {14'h0, readData});
  endtask
  task rw(input logic [1:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask
  task rr(input logic [1:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 cmp("regRdData", e, regRdData);
    @(posedge core_clk);
  endtask
  initial begin
    logic [6:0] c;
    logic [8:0] wl, rl;
    logic [17:0] wd, ex;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    pm.preload();
    rr(2'h1, 32'h4);
    foreach (ROWS[i]) begin
      {c, wl, wd, rl, ex} = ROWS[i];
      rw(2'h0, {25'h0, c});
      pm.wr(wl, wd, 1'b1);
      pm.rd(rl, 1'b1);
      cd(ex);
    end
    rw(2'h0, 32'h0);
    rr(2'h1, 32'h7);
    pm.wr(9'h003, 18'h0_0055, 1'b1);
    rw(2'h0, 32'h5);
    pm.wr(9'h003, 18'h0_0066, 1'b0);
    pm.rd(9'h003, 1'b1);
    cd(18'h0_01A5);
    pm.rd(9'h007, 1'b0);
    cd(18'h0_01A5);
    rr(2'h2, 32'h1A5);
    rw(2'h0, 32'h15);
    pm.rd(9'h007, 1'b1);
    pm.rd(9'h003, 1'b1);
    cd(18'h0_0007);
    rw(2'h0, 32'h65);
    pm.rd(9'h003, 1'b1);
    cmp("midData", 32'h7, {14'h0, midData});
    cd(18'h0_01A5);
    fork
      pm.wr(9'h00C, 18'h0_00CC, 1'b1);
      pm.rd(9'h007, 1'b1);
    join
    cd(18'h0_0007);
    pm.rd(9'h00C, 1'b1);
    cd(18'h0_00CC);
    rst_n <= 1'b0;
    pm.wr(9'h003, 18'h0_0077, 1'b1);
    cd(18'h0);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rr(2'h0, 32'h5);
    rr(2'h3, 32'h0);
    pm.rd(9'h003, 1'b1);
    cd(18'h0_01A5);
    test_done();
  end
endmodule
bind tps_two_port_sram tps_two_port_sram_props chk (.core_clk, .rst_n,
  .readClk, .readStrobe, .readData, .regAddr, .regWrData, .regWr, .regRd,
  .regRdData);
